/* logic/sar_pkg.sv */
// Package with constants and types for the SAR converter control block.
package sar_pkg;
  localparam int          DATA_WIDTH      = 16;
  localparam int          CLK_PERIOD_NS   = 40;
  localparam int          CONV_MAX_NS     = 35000;
  localparam int          CONV_MAX_CYCLES = CONV_MAX_NS / CLK_PERIOD_NS;
  localparam logic [15:0] PRESET_WORD     = 16'h7FFF;
  localparam logic [15:0] RESET_WORD      = 16'h7FFF;
  localparam logic [3:0]  LAST_BIT        = 4'h0;
  localparam logic [3:0]  FIRST_BIT       = 4'hF;
  localparam int          MSB_POS         = 15;

  typedef enum logic [1:0] {
    SAR_IDLE,
    SAR_TRIAL
  } sar_state_type;
endpackage

/* logic/sar_edge_fall.sv */
// Falling edge detector for the convert command input.
`timescale 1ns/1ns
module sar_edge_fall (
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  input  wire logic level_i,
  output logic      fall_o
);
  logic last_reg;
  logic last_next;

  always_comb begin
    last_next = level_i;
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      last_reg <= 1'b0;
    end else begin
      last_reg <= last_next;
    end
  end

  assign fall_o = last_reg & ~level_i;
endmodule

/* logic/sar_convert_control.sv */
// Successive-approximation control with output coding selection.
`timescale 1ns/1ns
// Notes on behaviour
// - Start conversion on convert command falling edge.
// - Ignore convert edges while converting.
// - Start resets logic; MSB low, others high.
// - Status high for whole conversion.
// - Trial bits MSB first, low then decide.
// - One cycle per bit; done within 35 us.
// - Status low when last bit decided.
// - Unipolar straight binary; bipolar offset or twos.
// - True and complemented MSB outputs provided.
// - Unipolar codes zero, half, full scale.
// - Twos complement is offset binary MSB inverted.
module sar_convert_control (
  input  wire logic        core_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        convert_cmd_i,
  input  wire logic        compare_high_i,
  output logic [15:0]      trial_word_o,
  output logic [15:0]      data_o,
  output logic             msb_true_o,
  output logic             msb_comp_o,
  output logic [7:0]       data_upper_o,
  output logic [7:0]       data_lower_o,
  output logic             status_o
);
  sar_pkg::sar_state_type state_reg;
  sar_pkg::sar_state_type state_next;
  logic [15:0]            word_reg;
  logic [15:0]            word_next;
  logic [3:0]             bit_reg;
  logic [3:0]             bit_next;
  logic                   status_reg;
  logic                   status_next;
  logic                   start_fall;

  // Edges sampled at 40 ns; a legal 100 ns pulse is always seen.
  sar_edge_fall u_fall (
    .clk_i     (core_clk_i),
    .reset_n_i (reset_n_i),
    .level_i   (convert_cmd_i),
    .fall_o    (start_fall)
  );

  // The comparator answers high when the input exceeds the trial
  // level, so the trial bit is kept set; otherwise it stays cleared.
  always_comb begin
    state_next  = state_reg;
    word_next   = word_reg;
    bit_next    = bit_reg;
    status_next = status_reg;
    case (state_reg)
      sar_pkg::SAR_IDLE: begin
        if (start_fall) begin
          word_next   = sar_pkg::PRESET_WORD;
          bit_next    = sar_pkg::FIRST_BIT;
          status_next = 1'b1;
          state_next  = sar_pkg::SAR_TRIAL;
        end
      end
      sar_pkg::SAR_TRIAL: begin
        // The trial bit is low on the DAC for this one cycle and the
        // answer is taken at its closing edge, 16 cycles in all.
        word_next[bit_reg] = compare_high_i;
        if (bit_reg == sar_pkg::LAST_BIT) begin
          status_next = 1'b0;
          state_next  = sar_pkg::SAR_IDLE;
        end else begin
          bit_next   = bit_reg - 4'h1;
          state_next = sar_pkg::SAR_TRIAL;
        end
      end
      default: begin
        state_next = sar_pkg::SAR_IDLE;
      end
    endcase
  end

  // Convert edges seen outside SAR_IDLE are simply dropped.
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      state_reg  <= sar_pkg::SAR_IDLE;
      word_reg   <= sar_pkg::RESET_WORD;
      bit_reg    <= sar_pkg::FIRST_BIT;
      status_reg <= 1'b0;
    end else begin
      state_reg  <= state_next;
      word_reg   <= word_next;
      bit_reg    <= bit_next;
      status_reg <= status_next;
    end
  end

  // Trial word for the DAC: active trial bit forced low.
  always_comb begin
    trial_word_o = word_reg;
    if (state_reg == sar_pkg::SAR_TRIAL) begin
      trial_word_o[bit_reg] = 1'b0;
    end
  end

  // Word register holds still in idle, so outputs stay stable.
  assign data_o       = word_reg;
  assign msb_true_o   = word_reg[sar_pkg::MSB_POS];
  assign msb_comp_o   = ~word_reg[sar_pkg::MSB_POS];
  assign data_upper_o = word_reg[15:8];
  assign data_lower_o = word_reg[7:0];
  assign status_o     = status_reg;
endmodule

/* testbench/sar_chk_assertions.sv */
// Port checker for the converter control block.
`timescale 1ns/1ns
module sar_chk (
  input wire logic        core_clk_i,
  input wire logic        reset_n_i,
  input wire logic        convert_cmd_i,
  input wire logic [15:0] data_o,
  input wire logic        msb_true_o,
  input wire logic        msb_comp_o,
  input wire logic        status_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  chk_start_preset:
  assert property ($fell(convert_cmd_i) && !status_o |=>
    status_o && data_o == 16'h7FFF) else $error("preset");
  chk_busy_len:
  assert property ($rose(status_o) |-> status_o[*8] ##9 $fell(status_o))
    else $error("busy");
  chk_conv_time:
  assert property ($rose(status_o) |-> ##[16:875] !status_o) else $error("t");
  chk_msb_first:
  assert property ($rose(status_o) |-> ##1 data_o[14:0] == 15'h7FFF)
    else $error("msb");
  chk_lsb_last:
  assert property ($fell(status_o) |-> $stable(data_o[15:1])) else $error("lsb");
  chk_result_hold:
  assert property (!status_o ##1 !status_o |-> $stable(data_o)) else $error("h");
  chk_msb_true:
  assert property (msb_true_o == data_o[15]) else $error("true");
  chk_msb_comp:
  assert property (msb_comp_o != data_o[15]) else $error("comp");
endmodule

/* testbench/sar_front_model.sv */
// Analog front end and comparator facing the converter.
`timescale 1ns/1ns
module sar_front_model (
  input  wire logic [15:0] level_i,
  input  wire logic [15:0] trial_i,
  output logic             cmp_o
);
  // An input above the trial level keeps the trial bit set.
  assign cmp_o = level_i > trial_i;
endmodule

/* testbench/test_sar_convert_control.sv */
// Self-checking bench for the converter control block.
`timescale 1ns/1ns
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin num_errors++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module test_sar_convert_control;
  logic        clk = 1'b0, rst_n = 1'b0, conv = 1'b0, cmp, st, mt, mc;
  logic [15:0] lvl = 16'h0000, trial, data;
  logic [7:0]  up, lo;
  int          num_errors = 0, compares = 0, seed = 32'h8A1D;
  logic [15:0] codes [5] = '{16'h0000, 16'h0001, 16'h8000, 16'h7FFF, 16'hFFFF};
  always #20 clk = ~clk;
  sar_convert_control dut (.core_clk_i(clk), .reset_n_i(rst_n),
    .convert_cmd_i(conv), .compare_high_i(cmp), .trial_word_o(trial),
    .data_o(data), .msb_true_o(mt), .msb_comp_o(mc), .data_upper_o(up),
    .data_lower_o(lo), .status_o(st));
  sar_front_model front (.level_i(lvl), .trial_i(trial), .cmp_o(cmp));
  task automatic run(input logic [15:0] v);
    int n;
    n = 0;
    lvl <= v;
    conv <= 1'b1;
    repeat (3) @(posedge clk);
    conv <= 1'b0;
    repeat (2) @(posedge clk);
    #1 `CHK("busy", 1'b1, st)
    @(posedge clk);
    conv <= 1'b1;
    repeat (3) @(posedge clk);
    // A second start while busy must not disturb the result.
    conv <= 1'b0;
    while (st !== 1'b0 && n < 900) begin
      @(posedge clk);
      #1 n++;
    end
    if (n >= 900) num_errors++;
    `CHK("result", v, data)
    `CHK("twos", v ^ 16'h8000, {mc, data[14:0]})
    `CHK("bytes", v, {up, lo})
    $display("test %h done", v);
    @(posedge clk);
  endtask
  task automatic report_and_stop();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    foreach (codes[i]) run(codes[i]);
    repeat (4) run(16'($random(seed)));
    report_and_stop();
  end
  initial begin
    #200000;
    num_errors++;
    report_and_stop();
  end
endmodule
bind sar_convert_control sar_chk chk (.core_clk_i, .reset_n_i, .convert_cmd_i,
  .data_o, .msb_true_o, .msb_comp_o, .status_o);
